// *** verilog/tlc_pkg.sv ***
// tlc_pkg: shared types and constants of the loop code unit.
// assumes one core clock; bit slots are marked by strobes from the framer.
`default_nettype none
package tlc_pkg;
    typedef enum logic [1:0] {
        FRM_ESF = 2'h0,
        FRM_SF = 2'h1,
        FRM_SLC = 2'h2,
        FRM_DM = 2'h3
    } tlc_framing_t;

    // in-band: line, net unit 4, net unit 5; out-band: line, payload, net unit
    typedef enum logic [1:0] {
        CODE_LINE = 2'h0,
        CODE_NIU4 = 2'h1,
        CODE_NIU5 = 2'h2,
        CODE_PAYLOAD = 2'h3
    } tlc_code_t;

    typedef enum logic [2:0] {
        GEN_IDLE = 3'b001,
        GEN_UP = 3'b010,
        GEN_DOWN = 3'b100
    } tlc_gen_t;

    // position marks of the current transmit bit slot
    typedef struct packed {
        logic fbit;
        logic dl;
        logic e1_abit;
        logic e1_ybit;
    } tlc_pos_t;

    // one line bit and its framing mark
    typedef struct packed {
        logic data;
        logic fbit;
    } tlc_lbit_t;

    localparam int LB_W = 2;
    localparam tlc_lbit_t LB_ONES = 2'h2;

    // in-band patterns, first bit sent is bit (len-1)
    localparam logic [4:0] IB_LINE_UP = 5'h10;
    localparam logic [2:0] IB_LINE_UP_LEN = 3'h5;
    localparam logic [4:0] IB_LINE_DN = 5'h04;
    localparam logic [2:0] IB_LINE_DN_LEN = 3'h3;
    localparam logic [4:0] IB_NIU4_UP = 5'h0C;
    localparam logic [2:0] IB_NIU4_UP_LEN = 3'h4;
    localparam logic [4:0] IB_NIU4_DN = 5'h0E;
    localparam logic [2:0] IB_NIU4_DN_LEN = 3'h4;
    localparam logic [4:0] IB_NIU5_UP = 5'h18;
    localparam logic [2:0] IB_NIU5_UP_LEN = 3'h5;
    localparam logic [4:0] IB_NIU5_DN = 5'h1C;
    localparam logic [2:0] IB_NIU5_DN_LEN = 3'h5;
    localparam int IB_MAX = 5;

    // out-band codewords, sent msb first
    localparam logic [15:0] OB_LINE_UP = 16'h0EFF;
    localparam logic [15:0] OB_LINE_DN = 16'h38FF;
    localparam logic [15:0] OB_PAY_UP = 16'h14FF;
    localparam logic [15:0] OB_PAY_DN = 16'h32FF;
    localparam logic [15:0] OB_NIU_UP = 16'h12FF;
    localparam logic [15:0] OB_NIU_DN = 16'h24FF;
    localparam logic [3:0] OB_LAST = 4'hF;
endpackage
`default_nettype wire

// *** verilog/tlc_fifo.sv ***
// tlc_fifo: synchronous fifo with valid/ready on both sides.
// assumes one clock and a synchronous active-low reset.
`default_nettype none
module tlc_fifo #(
    parameter int W = 2,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp, rp, next_wp, next_rp;
    logic [CW-1:0] next_count;
    logic push, pop;

    assign in_ready = (count != CW'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_wp = push ? AW'(wp + 1'b1) : wp;
        next_rp = pop ? AW'(rp + 1'b1) : rp;
        next_count = count;
        if (push && !pop) begin
            next_count = CW'(count + 1'b1);
        end else if (pop && !push) begin
            next_count = CW'(count - 1'b1);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wp <= '0;
            rp <= '0;
            count <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
            count <= next_count;
        end
    end

    // storage carries no reset; occupancy guards every read
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end
endmodule // tlc_fifo
`default_nettype wire

// *** verilog/tlc_loop_unit.sv ***
// tlc_loop_unit: t1 loop code generator/detector, loopback steering and
// e1 remote alarm bit insertion on the transmit bit stream.
// assumes a framer on the same clock strobes RX_VALID per received bit and
// TX_REQ per transmit slot, with the slot's position marks on TX_POS.
`default_nettype none
// Operation
// - in e1 with remote alarm on, timeslot 0 a bit is sent as one.
// - in e1 with multiframe remote alarm on, the timeslot 16 y bit is one.
// - e1 mode turns off all loop code generation, detection and looping.
// - out-band codes are used only with esf framing, else in-band.
// - loop-up command sends the up code, loop-down command the down code.
// - in-band codes repeat 10000/100, 1100/1110 and 11000/11100.
// - out-band codewords are sent as printed, eight bits then ones.
// - inserted mode lets framing bits replace code bits, overwritten not.
// - with auto response, loop-up detect loops the tester, loop-down frees.
// - line loop control up sends the whole received stream to transmit.
// - payload loop control up sends the received payload to transmit.
// - loop-up lamp is lit while a loop-up code is detected.
// - loop-down lamp is lit while a loop-down code is detected.
// - alarm indication replaces all transmit data by unframed ones.
module tlc_loop_unit
    import tlc_pkg::*;
#(
    parameter int unsigned QUAL_BITS = 32'h0000_1388,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic E1_MODE,
    input wire tlc_framing_t FRAMING,
    input wire logic OUT_BAND,
    input wire tlc_code_t CODE_SEL,
    input wire logic INSERTED,
    input wire logic LOOP_UP_CMD,
    input wire logic LOOP_DOWN_CMD,
    input wire logic GEN_OFF,
    input wire logic AUTO_RESP,
    input wire logic LINE_LOOP_CTL,
    input wire logic PAYLOAD_LOOP_CTL,
    input wire logic AIS_EN,
    input wire logic RAI_EN,
    input wire logic MULTIFRAME_REMOTE_ALARM_EN,
    input wire logic RX_VALID,
    input wire tlc_lbit_t RX_BIT,
    output logic RX_READY,
    input wire logic TX_REQ,
    input wire tlc_pos_t TX_POS,
    input wire logic TX_LOCAL,
    output logic TX_OUT,
    output logic TX_VALID,
    output logic LOOPUP_LAMP,
    output logic LOOP_DOWN_SEEN_LAMP,
    output logic LOOPED,
    output logic LINE_LOOPED,
    output logic PAYLOAD_LOOPED
);
    localparam int CW = $clog2(FIFO_DEPTH+1);
    localparam logic [CW-1:0] RDY_LIMIT = CW'(FIFO_DEPTH - 2);

    // in-band code lookup: {length, pattern}
    function automatic logic [7:0] ib_code(input tlc_code_t sel, input logic up);
        logic [7:0] r;
        unique case (sel)
            CODE_NIU4: r = up ? {IB_NIU4_UP_LEN, IB_NIU4_UP} : {IB_NIU4_DN_LEN, IB_NIU4_DN};
            CODE_NIU5: r = up ? {IB_NIU5_UP_LEN, IB_NIU5_UP} : {IB_NIU5_DN_LEN, IB_NIU5_DN};
            // no in-band payload code; line code stands in
            default: r = up ? {IB_LINE_UP_LEN, IB_LINE_UP} : {IB_LINE_DN_LEN, IB_LINE_DN};
        endcase
        return r;
    endfunction

    function automatic logic [15:0] ob_code(input tlc_code_t sel, input logic up);
        logic [15:0] r;
        unique case (sel)
            CODE_LINE: r = up ? OB_LINE_UP : OB_LINE_DN;
            CODE_PAYLOAD: r = up ? OB_PAY_UP : OB_PAY_DN;
            default: r = up ? OB_NIU_UP : OB_NIU_DN;
        endcase
        return r;
    endfunction

    // true when the newest len bits are a rotation of the pattern
    function automatic logic rot_match(input logic [IB_MAX-1:0] h,
                                       input logic [4:0] pat, input logic [2:0] len);
        logic hit, ok;
        int k;
        hit = 1'b0;
        for (int r = 0; r < IB_MAX; r++) begin
            ok = (r < int'(len));
            for (int i = 0; i < IB_MAX; i++) begin
                k = (i + r >= int'(len)) ? i + r - int'(len) : i + r;
                if (i < int'(len) && k < IB_MAX && h[i] != pat[k]) begin
                    ok = 1'b0;
                end
            end
            hit = hit | ok;
        end
        return hit;
    endfunction

    logic t1;
    logic ob_ok;
    logic rx_take;
    logic det_bit;
    logic loop_any;
    assign t1 = !E1_MODE;
    assign ob_ok = OUT_BAND && (FRAMING == FRM_ESF);
    assign rx_take = RX_VALID && RX_READY;
    // framing bits carry no code in inserted mode
    assign det_bit = rx_take && t1 && !(INSERTED && RX_BIT.fbit);
    assign loop_any = LINE_LOOPED || PAYLOAD_LOOPED;

    // receive history, newest bit in position 0
    logic [IB_MAX-1:0] hist, next_hist;
    always_comb begin
        next_hist = hist;
        if (det_bit) begin
            next_hist = {hist[IB_MAX-2:0], RX_BIT.data};
        end
    end
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            hist <= '0;
        end else begin
            hist <= next_hist;
        end
    end

    // detector 0 watches the up code, detector 1 the down code
    logic [1:0] seen;
    genvar d;
    generate
        for (d = 0; d < 2; d++) begin : g_det
            logic [7:0] c;
            logic periodic;
            logic [31:0] cnt, next_cnt;
            logic hit, next_hit;
            assign c = ib_code(CODE_SEL, d == 0);
            assign periodic = (RX_BIT.data == hist[c[7:5] - 3'h1]);
            always_comb begin
                next_cnt = cnt;
                next_hit = hit;
                if (!t1) begin
                    next_cnt = '0;
                    next_hit = 1'b0;
                end else if (det_bit) begin
                    if (!periodic) begin
                        next_cnt = '0;
                        next_hit = 1'b0;
                    end else begin
                        if (cnt < QUAL_BITS) begin
                            next_cnt = 32'(cnt + 1'b1);
                        end
                        if (cnt >= QUAL_BITS && rot_match(next_hist, c[4:0], c[7:5])) begin
                            next_hit = 1'b1;
                        end
                    end
                end
            end
            always_ff @(posedge CORE_CLK) begin
                if (!NRST) begin
                    cnt <= '0;
                    hit <= 1'b0;
                end else begin
                    cnt <= next_cnt;
                    hit <= next_hit;
                end
            end
            assign seen[d] = hit;
        end
    endgenerate

    // loop state and lamps
    logic [1:0] seen_d;
    logic next_looped, next_line, next_pay;
    always_comb begin
        next_looped = LOOPED;
        if (!t1) begin
            next_looped = 1'b0;
        end else if (AUTO_RESP && seen[0] && !seen_d[0]) begin
            next_looped = 1'b1;
        end else if (AUTO_RESP && seen[1] && !seen_d[1]) begin
            next_looped = 1'b0;
        end
        next_line = t1 && (LINE_LOOP_CTL || next_looped);
        next_pay = t1 && PAYLOAD_LOOP_CTL && !next_line;
    end
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            seen_d <= '0;
            LOOPED <= 1'b0;
            LINE_LOOPED <= 1'b0;
            PAYLOAD_LOOPED <= 1'b0;
            LOOPUP_LAMP <= 1'b0;
            LOOP_DOWN_SEEN_LAMP <= 1'b0;
        end else begin
            seen_d <= seen;
            LOOPED <= next_looped;
            LINE_LOOPED <= next_line;
            PAYLOAD_LOOPED <= next_pay;
            LOOPUP_LAMP <= seen[0];
            LOOP_DOWN_SEEN_LAMP <= seen[1];
        end
    end

    // loop code generator
    tlc_gen_t gen, next_gen;
    logic [3:0] ptr, next_ptr;
    logic [7:0] gc;
    logic [15:0] gw;
    logic code_bit;
    assign gc = ib_code(CODE_SEL, gen == GEN_UP);
    assign gw = ob_code(CODE_SEL, gen == GEN_UP);
    assign code_bit = ob_ok ? gw[OB_LAST - ptr] : gc[3'(gc[7:5] - 3'h1 - ptr[2:0])];

    always_comb begin
        next_gen = gen;
        next_ptr = ptr;
        if (!t1 || GEN_OFF) begin
            next_gen = GEN_IDLE;
            next_ptr = '0;
        end else if (LOOP_UP_CMD) begin
            next_gen = GEN_UP;
            next_ptr = '0;
        end else if (LOOP_DOWN_CMD) begin
            next_gen = GEN_DOWN;
            next_ptr = '0;
        end else if (TX_REQ && gen != GEN_IDLE) begin
            if (ob_ok) begin
                if (TX_POS.dl) begin
                    next_ptr = 4'(ptr + 1'b1);
                end
            end else if (ptr[2:0] == 3'(gc[7:5] - 3'h1)) begin
                next_ptr = '0;
            end else begin
                next_ptr = 4'(ptr + 1'b1);
            end
        end
    end
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            gen <= GEN_IDLE;
            ptr <= '0;
        end else begin
            gen <= next_gen;
            ptr <= next_ptr;
        end
    end

    // loopback buffer: received bits wait here for transmit slots
    logic f_in_ready, f_out_valid, f_pop;
    logic [LB_W-1:0] f_out;
    logic [CW-1:0] f_cnt;
    tlc_lbit_t lb;
    assign f_pop = TX_REQ && loop_any;
    assign lb = f_out_valid ? tlc_lbit_t'(f_out) : LB_ONES;

    tlc_fifo #(
        .W(LB_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(CORE_CLK),
        .nrst(NRST),
        .in_valid(rx_take && loop_any),
        .in_ready(f_in_ready),
        .in_data(RX_BIT),
        .out_valid(f_out_valid),
        .out_ready(f_pop),
        .out_data(f_out),
        .count(f_cnt)
    );

    // transmit mux
    logic tx_bit, next_tx_out, next_rx_ready;
    always_comb begin
        tx_bit = TX_LOCAL;
        if (AIS_EN) begin
            tx_bit = 1'b1;
        end else if (!t1) begin
            if (RAI_EN && TX_POS.e1_abit) begin
                tx_bit = 1'b1;
            end
            if (MULTIFRAME_REMOTE_ALARM_EN && TX_POS.e1_ybit) begin
                tx_bit = 1'b1;
            end
        end else if (LINE_LOOPED) begin
            tx_bit = lb.data;
        end else if (PAYLOAD_LOOPED) begin
            tx_bit = TX_POS.fbit ? TX_LOCAL : lb.data;
        end else if (gen != GEN_IDLE) begin
            if (ob_ok) begin
                tx_bit = TX_POS.dl ? code_bit : TX_LOCAL;
            end else begin
                tx_bit = (INSERTED && TX_POS.fbit) ? TX_LOCAL : code_bit;
            end
        end
        next_tx_out = TX_REQ ? tx_bit : TX_OUT;
        // two words of margin cover the registered ready lag
        next_rx_ready = !loop_any || (f_in_ready && f_cnt < RDY_LIMIT);
    end
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            TX_OUT <= 1'b1;
            TX_VALID <= 1'b0;
            RX_READY <= 1'b1;
        end else begin
            TX_OUT <= next_tx_out;
            TX_VALID <= TX_REQ;
            RX_READY <= next_rx_ready;
        end
    end
endmodule // tlc_loop_unit
`default_nettype wire

// *** testbench/tlc_far_end.sv ***
// far-end line equipment model: sends a repeating code on the rx stream.
// assumes the unit's clock and reset; holds each bit until it is taken.
`default_nettype none
module tlc_far_end
    import tlc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic [4:0] pat,
    input wire logic [2:0] len,
    input wire logic ready,
    output logic valid,
    output tlc_lbit_t lbit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] idx;
    logic data;
    assign lbit = {data, 1'b0};
    always @(posedge clk) begin
        if (!nrst) begin
            idx <= 3'h0;
            valid <= 1'b0;
            data <= 1'b0;
        end else if (!run) begin
            // a bit already offered stays on the line until it is taken
            if (!valid || ready) begin
                idx <= 3'h0;
                valid <= 1'b0;
                data <= ~data; // idle line must not look like a held bit
            end
        end else if (!valid || ready) begin
            valid <= 1'b1;
            data <= pat[len - 3'h1 - idx];
            idx <= (idx + 3'h1 == len) ? 3'h0 : idx + 3'h1;
        end
    end
endmodule // tlc_far_end
`default_nettype wire

// *** testbench/tlc_loop_unit_asserts.sv ***
// checker of the loop code unit, bound to its top ports.
// assumes one clock domain and the synchronous active-low reset.
`default_nettype none
module tlc_loop_unit_asserts
    import tlc_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic E1_MODE,
    input wire logic AUTO_RESP,
    input wire logic LINE_LOOP_CTL,
    input wire logic PAYLOAD_LOOP_CTL,
    input wire logic AIS_EN,
    input wire logic RAI_EN,
    input wire logic MULTIFRAME_REMOTE_ALARM_EN,
    input wire logic RX_VALID,
    input wire logic RX_READY,
    input wire logic TX_REQ,
    input wire tlc_pos_t TX_POS,
    input wire logic TX_LOCAL,
    input wire logic TX_OUT,
    input wire logic TX_VALID,
    input wire logic LOOPUP_LAMP,
    input wire logic LOOP_DOWN_SEEN_LAMP,
    input wire logic LOOPED,
    input wire logic LINE_LOOPED,
    input wire logic PAYLOAD_LOOPED
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    ais_ones_a: assert property (TX_REQ && AIS_EN |=> TX_OUT)
        else $error("ais slot not sent as one");
    e1_abit_a: assert property (TX_REQ && E1_MODE && RAI_EN && TX_POS.e1_abit |=> TX_OUT)
        else $error("a bit not forced");
    e1_ybit_a: assert property (TX_REQ && E1_MODE && MULTIFRAME_REMOTE_ALARM_EN && TX_POS.e1_ybit |=> TX_OUT)
        else $error("y bit not forced");
    e1_noloop_a: assert property (E1_MODE [*2] |-> !LINE_LOOPED && !PAYLOAD_LOOPED && !LOOPED)
        else $error("loop active in e1");
    e1_nolamp_a: assert property (E1_MODE [*3] |-> !LOOPUP_LAMP && !LOOP_DOWN_SEEN_LAMP)
        else $error("lamp lit in e1");
    line_up_a: assert property (!E1_MODE && LINE_LOOP_CTL |=> LINE_LOOPED)
        else $error("line loop not taken");
    pay_release_a: assert property (!PAYLOAD_LOOP_CTL |=> !PAYLOAD_LOOPED)
        else $error("payload loop not released");
    pay_fbit_a: assert property (TX_REQ && !E1_MODE && !AIS_EN && PAYLOAD_LOOPED && !LINE_LOOPED
        && TX_POS.fbit |=> TX_OUT == $past(TX_LOCAL))
        else $error("payload loop framing bit wrong");
    auto_hold_a: assert property (!AUTO_RESP && !E1_MODE |=> $stable(LOOPED))
        else $error("loop state moved without auto response");
    up_lamp_a: assert property ($rose(LOOPUP_LAMP) |-> $past(RX_VALID && RX_READY, 2))
        else $error("up lamp without received bit");
    dn_lamp_a: assert property ($rose(LOOP_DOWN_SEEN_LAMP) |-> $past(RX_VALID && RX_READY, 2))
        else $error("down lamp without received bit");
    slot_ans_a: assert property (TX_REQ |=> TX_VALID)
        else $error("slot not answered");
    out_hold_a: assert property (!TX_VALID |-> $stable(TX_OUT))
        else $error("tx bit moved between slots");
endmodule // tlc_loop_unit_asserts
bind tlc_loop_unit tlc_loop_unit_asserts tlc_loop_unit_asserts_inst (.CORE_CLK(CORE_CLK),
    .NRST(NRST), .E1_MODE(E1_MODE), .AUTO_RESP(AUTO_RESP), .LINE_LOOP_CTL(LINE_LOOP_CTL),
    .PAYLOAD_LOOP_CTL(PAYLOAD_LOOP_CTL), .AIS_EN(AIS_EN), .RAI_EN(RAI_EN), .MULTIFRAME_REMOTE_ALARM_EN(MULTIFRAME_REMOTE_ALARM_EN),
    .RX_VALID(RX_VALID), .RX_READY(RX_READY), .TX_REQ(TX_REQ), .TX_POS(TX_POS),
    .TX_LOCAL(TX_LOCAL), .TX_OUT(TX_OUT), .TX_VALID(TX_VALID), .LOOPUP_LAMP(LOOPUP_LAMP),
    .LOOP_DOWN_SEEN_LAMP(LOOP_DOWN_SEEN_LAMP), .LOOPED(LOOPED), .LINE_LOOPED(LINE_LOOPED),
    .PAYLOAD_LOOPED(PAYLOAD_LOOPED));
`default_nettype wire

// *** testbench/tlc_loop_unit_tb_top.sv ***
// bench of the loop code unit: generator, alarms, loopback, detection.
// assumes the far-end model on the rx side and the bound checker.
`default_nettype none
module tlc_loop_unit_tb_top
    import tlc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic CORE_CLK = 0, NRST = 0, E1_MODE = 0, OUT_BAND = 0, INSERTED = 0, GEN_OFF = 0;
    logic LOOP_UP_CMD = 0, LOOP_DOWN_CMD = 0, AUTO_RESP = 0, LINE_LOOP_CTL = 0;
    logic PAYLOAD_LOOP_CTL = 0, AIS_EN = 0, RAI_EN = 0, MULTIFRAME_REMOTE_ALARM_EN = 0, TX_REQ = 0, TX_LOCAL = 0;
    tlc_framing_t FRAMING = FRM_SF;
    tlc_code_t CODE_SEL = CODE_LINE;
    tlc_pos_t TX_POS = '0;
    tlc_lbit_t RX_BIT;
    logic RX_VALID, RX_READY, TX_OUT, TX_VALID, LOOPUP_LAMP, LOOP_DOWN_SEEN_LAMP;
    logic LOOPED, LINE_LOOPED, PAYLOAD_LOOPED, fe_run = 0;
    logic [4:0] fe_pat = 5'h00;
    logic [2:0] fe_len = 3'h5;
    logic [1:0] b;
    int error_cnt = 0, num_checks = 0, n, i, k;
    always #4 CORE_CLK = ~CORE_CLK;
    tlc_loop_unit #(.QUAL_BITS(20), .FIFO_DEPTH(16)) tlc_loop_unit_inst (.CORE_CLK(CORE_CLK),
        .NRST(NRST), .E1_MODE(E1_MODE), .FRAMING(FRAMING), .OUT_BAND(OUT_BAND),
        .CODE_SEL(CODE_SEL), .INSERTED(INSERTED), .LOOP_UP_CMD(LOOP_UP_CMD),
        .LOOP_DOWN_CMD(LOOP_DOWN_CMD), .GEN_OFF(GEN_OFF), .AUTO_RESP(AUTO_RESP),
        .LINE_LOOP_CTL(LINE_LOOP_CTL), .PAYLOAD_LOOP_CTL(PAYLOAD_LOOP_CTL), .AIS_EN(AIS_EN),
        .RAI_EN(RAI_EN), .MULTIFRAME_REMOTE_ALARM_EN(MULTIFRAME_REMOTE_ALARM_EN), .RX_VALID(RX_VALID), .RX_BIT(RX_BIT),
        .RX_READY(RX_READY), .TX_REQ(TX_REQ), .TX_POS(TX_POS), .TX_LOCAL(TX_LOCAL),
        .TX_OUT(TX_OUT), .TX_VALID(TX_VALID), .LOOPUP_LAMP(LOOPUP_LAMP),
        .LOOP_DOWN_SEEN_LAMP(LOOP_DOWN_SEEN_LAMP), .LOOPED(LOOPED),
        .LINE_LOOPED(LINE_LOOPED), .PAYLOAD_LOOPED(PAYLOAD_LOOPED));
    tlc_far_end tlc_far_end_inst (.clk(CORE_CLK), .nrst(NRST), .run(fe_run), .pat(fe_pat),
        .len(fe_len), .ready(RX_READY), .valid(RX_VALID), .lbit(RX_BIT));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task results;
        if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task cyc(input int c);
        repeat (c) @(posedge CORE_CLK);
        #1;
    endtask
    // one slot; b returns {valid, bit} one cycle after the request
    task slot(input tlc_pos_t pos, input logic loc);
        cyc(1);
        TX_REQ = 1; TX_POS = pos; TX_LOCAL = loc;
        cyc(1);
        TX_REQ = 0;
        b = {TX_VALID, TX_OUT};
    endtask
    task cmd(input logic up);
        cyc(1);
        if (up) LOOP_UP_CMD = 1; else LOOP_DOWN_CMD = 1;
        cyc(1);
        LOOP_UP_CMD = 0; LOOP_DOWN_CMD = 0;
    endtask
    task wait_lamp(input logic dn);
        for (n = 0; n < 300 && (dn ? LOOP_DOWN_SEEN_LAMP : LOOPUP_LAMP) !== 1'b1; n++) cyc(1);
    endtask
    // out-band asked for without esf framing: in-band codes go out; payload uses line codes
    task t_inband;
        logic [4:0] p[8] = '{5'h10, 5'h04, 5'h0C, 5'h0E, 5'h18, 5'h1C, 5'h10, 5'h04};
        int l[8] = '{5, 3, 4, 4, 5, 5, 5, 3};
        OUT_BAND = 1;
        for (i = 0; i < 8; i++) begin
            CODE_SEL = tlc_code_t'(i / 2);
            FRAMING = tlc_framing_t'(1 + i % 3);
            cmd(i % 2 == 0);
            for (k = 0; k < 10; k++) begin
                slot('0, 1'b0);
                chk(b, {1'b1, p[i][l[i] - 1 - k % l[i]]});
            end
        end
    endtask
    task t_outband;
        logic [15:0] w[6] = '{16'h0EFF, 16'h38FF, 16'h14FF, 16'h32FF, 16'h12FF, 16'h24FF};
        tlc_code_t c[6] = '{CODE_LINE, CODE_LINE, CODE_PAYLOAD, CODE_PAYLOAD, CODE_NIU4, CODE_NIU4};
        FRAMING = FRM_ESF;
        for (i = 0; i < 6; i++) begin
            CODE_SEL = c[i];
            cmd(i % 2 == 0);
            for (k = 0; k < 16; k++) begin
                slot(4'h4, ~w[i][15 - k]);
                chk(b, {1'b1, w[i][15 - k]});
            end
            slot('0, 1'b0);
            chk(b, 2'h2);
        end
        FRAMING = FRM_SF; OUT_BAND = 0; CODE_SEL = CODE_LINE;
    endtask
    task t_insert;
        logic p;
        for (i = 1; i >= 0; i--) begin
            INSERTED = i[0];
            cmd(1);
            for (k = 0; k < 10; k++) begin
                p = (k % 5 == 0);
                slot((k % 3 == 2) ? 4'h8 : 4'h0, ~p);
                chk(b, {1'b1, (i == 1 && k % 3 == 2) ? ~p : p});
            end
        end
    endtask
    task t_alarm;
        GEN_OFF = 1;
        cmd(1);
        slot('0, 1'b0); chk(b, 2'h2);
        GEN_OFF = 0; AIS_EN = 1;
        slot(4'h8, 1'b0); chk(b, 2'h3);
        AIS_EN = 0; E1_MODE = 1; RAI_EN = 1; MULTIFRAME_REMOTE_ALARM_EN = 1; LINE_LOOP_CTL = 1;
        cmd(1);
        slot(4'h2, 1'b0); chk(b, 2'h3);
        slot(4'h1, 1'b0); chk(b, 2'h3);
        slot('0, 1'b0); chk(b, 2'h2);
        chk(LINE_LOOPED, 1'b0);
        E1_MODE = 0; RAI_EN = 0; MULTIFRAME_REMOTE_ALARM_EN = 0;
    endtask
    task t_fifo;
        fe_pat = 5'h00; fe_len = 3'h5; fe_run = 1;
        for (n = 0; n < 100 && RX_READY !== 1'b0; n++) cyc(1);
        chk(LINE_LOOPED, 1'b1);
        cyc(5);
        chk(RX_READY, 1'b0);
        fe_run = 0;
        for (k = 0; k < 20; k++) begin
            slot('0, 1'b1);
            if (b !== 2'h2) break;
        end
        // fifteen words under the ready margin plus the bit still held on the line
        chk(k == 16, 1'b1);
        chk(b, 2'h3);
        LINE_LOOP_CTL = 0; PAYLOAD_LOOP_CTL = 1;
        cyc(2);
        chk({LINE_LOOPED, PAYLOAD_LOOPED}, 2'h1);
        slot(4'h8, 1'b0); chk(b, 2'h2);
        slot('0, 1'b0); chk(b, 2'h3);
        PAYLOAD_LOOP_CTL = 0;
        cyc(2);
        chk(PAYLOAD_LOOPED, 1'b0);
    endtask
    // rx bits flow one a cycle, so the looped fifo is drained as fast
    task t_detect;
        AUTO_RESP = 1; TX_REQ = 1; fe_pat = 5'h10; fe_len = 3'h5; fe_run = 1;
        cyc(12);
        chk(LOOPUP_LAMP, 1'b0);
        wait_lamp(0);
        cyc(2);
        chk({LOOPUP_LAMP, LOOPED, LINE_LOOPED}, 3'h7);
        fe_run = 0; cyc(1);
        fe_pat = 5'h04; fe_len = 3'h3; fe_run = 1;
        wait_lamp(1);
        cyc(2);
        chk({LOOP_DOWN_SEEN_LAMP, LOOPUP_LAMP, LOOPED}, 3'h4);
        AUTO_RESP = 0; fe_run = 0; cyc(1);
        fe_pat = 5'h10; fe_len = 3'h5; fe_run = 1;
        wait_lamp(0);
        cyc(2);
        chk({LOOPUP_LAMP, LOOPED}, 2'h2);
        fe_run = 0; TX_REQ = 0;
    endtask
    initial begin
        cyc(4);
        NRST = 1;
        t_inband;
        t_outband;
        t_insert;
        t_alarm;
        t_fifo;
        t_detect;
        results;
    end
    initial begin
        #400000;
        error_cnt++;
        results;
    end
endmodule // tlc_loop_unit_tb_top
`default_nettype wire
